// ==== pcx_consts.vh ====
/*
 Constants for the management register bank: offsets, fields, resets, timing.
 Assumes inclusion by pcx_regbank.v only.
*/
`ifndef PCX_CONSTS_VH
`define PCX_CONSTS_VH
`define PCX_ADDR_CTL3      5'h0b
`define PCX_ADDR_IND_CTL   5'h0d
`define PCX_ADDR_IND_DATA  5'h0e
`define PCX_RST_CTL3       16'h0000
`define PCX_RST_IND_CTL    16'h0000
`define PCX_RST_IND_DATA   16'h0000
`define PCX_CTL3_WMASK     16'h007f
`define PCX_IND_CTL_WMASK  16'hc01f
`define PCX_BIT_POL        6
`define PCX_BIT_XOVER      5
`define PCX_BIT_FLD_RXER   3
`define PCX_BIT_FLD_MLT    2
`define PCX_BIT_FLD_SNR    1
`define PCX_BIT_FLD_NRG    0
`define PCX_FN_HI          15
`define PCX_FN_LO          14
`define PCX_DEV_HI         4
`define PCX_DEV_LO         0
`define PCX_DEV_EXT        5'h1f
`define PCX_FN_ADDR        2'h0
`define PCX_FN_DATA        2'h1
`define PCX_FN_INC_RW      2'h2
`define PCX_FN_INC_W       2'h3
`define PCX_CNT_RXER       6'h20
`define PCX_CNT_MLT        6'h14
`define PCX_CNT_SNR        6'h14
`define PCX_WIN_NS         10000
`define PCX_CLK_NS         8
`endif

// ==== pcx_regbank.v ====
/*
 Management register bank: third control register, indirect extended access
 and fast link-drop logic. Assumes a serial management engine on clk issues
 one-cycle read/write strobes with a 5-bit register address; extended
 registers live outside and answer reads in the same cycle.
*/
// How it works
// - Reserved bits of control three and indirect control ignore writes, read zero.
// - Bit six high keeps polarity; low inverts both pairs.
// - Bit five high swaps transmit and receive pairs; low keeps them normal.
// - Port mirroring is on only when bits five and six are both set.
// - Bit three drops link after 32 receive errors within 10 us.
// - Bit two drops link after 20 line code violations within 10 us.
// - Bit one drops link after 20 low SNR crossings within 10 us.
// - Bit zero drops link on energy loss, reacting well within 10 us.
// - Link drop is the OR of all enabled triggers.
// - Extended registers reached only through indirect control and address/data registers.
// - Function 00 writes to address/data load the extended pointer.
// - Function 01 accesses the pointed register; pointer unchanged.
// - Function 10 increments pointer after every read or write.
// - Function 11 increments pointer after writes only.
// - Device select other than 11111 makes address/data transactions ignored.
// - Address/data reads return pointer in function 00, else extended data.
`timescale 1ns/1ps
`include "pcx_consts.vh"
module pcx_regbank #(
  parameter WIN_CYC    = (`PCX_WIN_NS / `PCX_CLK_NS),
  parameter RXER_LIMIT = `PCX_CNT_RXER,
  parameter MLT_LIMIT  = `PCX_CNT_MLT,
  parameter SNR_LIMIT  = `PCX_CNT_SNR
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        clk_en,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [4:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire [15:0] ext_rdata,
  input  wire        rx_err_pin,
  input  wire        mlt3_viol_pin,
  input  wire        low_snr_pin,
  input  wire        energy_loss_pin,
  output reg  [15:0] reg_rdata,
  output reg         ext_wr,
  output reg         ext_rd,
  output reg  [15:0] ext_addr,
  output reg  [15:0] ext_wdata,
  output reg         pol_normal,
  output reg         pair_swap,
  output reg         port_mirror,
  output reg         link_drop
);
  reg  [15:0] ctl3_ff;
  reg  [15:0] ictl_ff;
  reg  [15:0] ptr_ff;
  reg  [3:0]  s1_ff;
  reg  [3:0]  s2_ff;
  reg  [2:0]  s3_ff;
  reg  [13:0] win_ff;
  reg  [5:0]  rxer_ff;
  reg  [5:0]  mlt_ff;
  reg  [5:0]  snr_ff;
  reg  [15:0] nxt_rdata;
  wire [1:0]  fn;
  wire        dev_ok;
  wire        data_hit_wr;
  wire        data_hit_rd;
  wire        ext_ok;
  wire        inc_ptr;
  wire [2:0]  rise;
  wire        win_end;
  wire        nxt_drop;

  // Saturating event counter, reset at each window boundary
  function [5:0] evt_cnt;
    input [5:0] cnt;
    input       ev;
    input       clr;
    begin
      if (clr)
        evt_cnt = {5'h00, ev};
      else if (ev && cnt != 6'h3f)
        evt_cnt = cnt + 6'h01;
      else
        evt_cnt = cnt;
    end
  endfunction

  wire        hit_ctl3_wr;
  wire        hit_ictl_wr;
  wire        hit_data;
  wire        ptr_load;
  wire        drop_rxer;
  wire        drop_mlt;
  wire        drop_snr;
  wire        drop_nrg;
  wire [13:0] win_last;

  // True when a strobe targets the given register
  function addr_hit;
    input [4:0] addr;
    input [4:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // Threshold test of an enabled event counter
  function over_limit;
    input       enable;
    input [5:0] cnt;
    input [5:0] limit;
    begin
      over_limit = enable && (cnt >= limit);
    end
  endfunction

  // Decode of the register bank
  assign hit_ctl3_wr = reg_wr && addr_hit(reg_addr, `PCX_ADDR_CTL3);
  assign hit_ictl_wr = reg_wr && addr_hit(reg_addr, `PCX_ADDR_IND_CTL);
  assign hit_data    = addr_hit(reg_addr, `PCX_ADDR_IND_DATA);
  assign fn          = ictl_ff[`PCX_FN_HI:`PCX_FN_LO];
  // Wrong device select drops the whole transaction
  assign dev_ok      = (ictl_ff[`PCX_DEV_HI:`PCX_DEV_LO] == `PCX_DEV_EXT);
  assign data_hit_wr = reg_wr && hit_data && dev_ok;
  assign data_hit_rd = reg_rd && hit_data && dev_ok;
  assign ext_ok      = (fn != `PCX_FN_ADDR);
  assign ptr_load    = data_hit_wr && !ext_ok;
  assign inc_ptr     = (fn == `PCX_FN_INC_RW && (data_hit_wr || data_hit_rd)) ||
                       (fn == `PCX_FN_INC_W && data_hit_wr);

  // Window length is a parameter so a bench may shorten it
  assign rise        = s2_ff[3:1] & ~s3_ff;
  assign win_last    = WIN_CYC[13:0] - 14'h0001;
  assign win_end     = (win_ff == win_last);

  // Fixed windows can split a burst; cheaper than a sliding window
  assign drop_rxer   = over_limit(ctl3_ff[`PCX_BIT_FLD_RXER], rxer_ff, RXER_LIMIT);
  assign drop_mlt    = over_limit(ctl3_ff[`PCX_BIT_FLD_MLT], mlt_ff, MLT_LIMIT);
  assign drop_snr    = over_limit(ctl3_ff[`PCX_BIT_FLD_SNR], snr_ff, SNR_LIMIT);
  assign drop_nrg    = ctl3_ff[`PCX_BIT_FLD_NRG] && s2_ff[0];
  assign nxt_drop    = drop_rxer || drop_mlt || drop_snr || drop_nrg;

  always @* begin
    nxt_rdata = 16'h0000;
    case (reg_addr)
      `PCX_ADDR_CTL3:     nxt_rdata = ctl3_ff & `PCX_CTL3_WMASK;
      `PCX_ADDR_IND_CTL:  nxt_rdata = ictl_ff & `PCX_IND_CTL_WMASK;
      `PCX_ADDR_IND_DATA: nxt_rdata = !dev_ok ? 16'h0000 : (ext_ok ? ext_rdata : ptr_ff);
      default:            nxt_rdata = 16'h0000;
    endcase
  end

  // Two-flop synchroniser; stage two and its one-cycle delayed copy s3_ff feed logic
  always @(posedge clk) begin
    if (!rst_n) begin
      s1_ff <= 4'h0;
      s2_ff <= 4'h0;
      s3_ff <= 3'h0;
    end else if (clk_en) begin
      s1_ff <= {rx_err_pin, mlt3_viol_pin, low_snr_pin, energy_loss_pin};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff[3:1];
    end
  end

  // Free-running window counter
  always @(posedge clk) begin
    if (!rst_n) begin
      win_ff <= 14'h0000;
    end else if (clk_en) begin
      if (win_end) begin
        win_ff <= 14'h0000;
      end else begin
        win_ff <= win_ff + 14'h0001;
      end
    end
  end

  // Event counters clear at each window boundary
  always @(posedge clk) begin
    if (!rst_n) begin
      rxer_ff <= 6'h00;
    end else if (clk_en) begin
      rxer_ff <= evt_cnt(rxer_ff, rise[2], win_end);
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      mlt_ff <= 6'h00;
    end else if (clk_en) begin
      mlt_ff <= evt_cnt(mlt_ff, rise[1], win_end);
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      snr_ff <= 6'h00;
    end else if (clk_en) begin
      snr_ff <= evt_cnt(snr_ff, rise[0], win_end);
    end
  end

  // Registered so the drop output is glitch free
  always @(posedge clk) begin
    if (!rst_n) begin
      link_drop <= 1'b0;
    end else if (clk_en) begin
      link_drop <= nxt_drop;
    end
  end

  // Control three; reserved bits never stored
  always @(posedge clk) begin
    if (!rst_n) begin
      ctl3_ff <= `PCX_RST_CTL3;
    end else if (clk_en) begin
      if (hit_ctl3_wr) begin
        ctl3_ff <= reg_wdata & `PCX_CTL3_WMASK;
      end
    end
  end

  // Indirect control; reserved bits never stored
  always @(posedge clk) begin
    if (!rst_n) begin
      ictl_ff <= `PCX_RST_IND_CTL;
    end else if (clk_en) begin
      if (hit_ictl_wr) begin
        ictl_ff <= reg_wdata & `PCX_IND_CTL_WMASK;
      end
    end
  end

  // Pointer loads in address mode, otherwise may post-increment
  always @(posedge clk) begin
    if (!rst_n) begin
      ptr_ff <= `PCX_RST_IND_DATA;
    end else if (clk_en) begin
      if (ptr_load) begin
        ptr_ff <= reg_wdata;
      end else if (inc_ptr) begin
        ptr_ff <= ptr_ff + 16'h0001;
      end
    end
  end

  // Read data holds until the next read strobe
  always @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      if (reg_rd) begin
        reg_rdata <= nxt_rdata;
      end
    end
  end

  // Extended strobes are one-cycle pulses
  always @(posedge clk) begin
    if (!rst_n) begin
      ext_wr <= 1'b0;
      ext_rd <= 1'b0;
    end else if (clk_en) begin
      ext_wr <= data_hit_wr && ext_ok;
      ext_rd <= data_hit_rd && ext_ok;
    end
  end

  // Address shows the pointer from before any increment
  always @(posedge clk) begin
    if (!rst_n) begin
      ext_addr  <= 16'h0000;
      ext_wdata <= 16'h0000;
    end else if (clk_en) begin
      ext_addr  <= ptr_ff;
      ext_wdata <= reg_wdata;
    end
  end

  // Pair controls follow control three one cycle later
  always @(posedge clk) begin
    if (!rst_n) begin
      pol_normal <= 1'b0;
    end else if (clk_en) begin
      pol_normal <= ctl3_ff[`PCX_BIT_POL];
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      pair_swap <= 1'b0;
    end else if (clk_en) begin
      pair_swap <= ctl3_ff[`PCX_BIT_XOVER];
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      port_mirror <= 1'b0;
    end else if (clk_en) begin
      port_mirror <= ctl3_ff[`PCX_BIT_POL] & ctl3_ff[`PCX_BIT_XOVER];
    end
  end
endmodule

// ==== pcx_regbank_asserts.sv ====
/* Port checker for pcx_regbank.
   Assumes clk with sync active-low rst_n; bound below. */
`timescale 1ns/1ps
module pcx_chk (
  input wire        clk, rst_n, clk_en, reg_wr, reg_rd, ext_wr, ext_rd,
  input wire        pol_normal, pair_swap, port_mirror, link_drop,
  input wire [4:0]  reg_addr,
  input wire [15:0] reg_rdata, ext_rdata, reg_wdata, ext_wdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_mir; port_mirror == (pol_normal & pair_swap); endproperty
  a_mir: assert property (p_mir) else $error("mirror not and of bits");
  property p_rst; $rose(rst_n) |-> !(link_drop | ext_wr | ext_rd | pol_normal) && reg_rdata == 0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
  property p_xw; ext_wr |-> $past(reg_wr & clk_en) && $past(reg_addr) == 5'h0e; endproperty
  a_xw: assert property (p_xw) else $error("stray extended write");
  property p_wd; ext_wr |-> ext_wdata == $past(reg_wdata); endproperty
  a_wd: assert property (p_wd) else $error("extended write data");
  property p_xr; ext_rd |-> $past(reg_rd & clk_en) && $past(reg_addr) == 5'h0e; endproperty
  a_xr: assert property (p_xr) else $error("stray extended read");
  property p_rd; ext_rd |-> reg_rdata == $past(ext_rdata); endproperty
  a_rd: assert property (p_rd) else $error("extended read data");
  property p_um; reg_rd && clk_en && !(reg_addr inside {5'h0b, 5'h0d, 5'h0e}) |=> reg_rdata == 0; endproperty
  a_um: assert property (p_um) else $error("unmapped read not zero");
  property p_one; !(ext_wr && ext_rd); endproperty
  a_one: assert property (p_one) else $error("both extended strobes");
  c_xw: cover property (ext_wr);
  c_xr: cover property (ext_rd);
  c_dr: cover property ($rose(link_drop));
endmodule
bind pcx_regbank pcx_chk i_pcx_chk (.*);

// ==== pcx_ext_model.sv ====
/* Extended register model, sixteen words.
   Assumes the bench tracks the pointer and feeds it on ptr. */
`timescale 1ns/1ps
module pcx_ext_model (
  input  wire        clk,
  input  wire        ext_wr,
  input  wire [15:0] ext_addr,
  input  wire [15:0] ext_wdata,
  input  wire [15:0] ptr,
  output wire [15:0] ext_rdata
);
  logic [15:0] mem [16];
  initial for (int i = 0; i < 16; i++) mem[i] = {4{i[3:0]}};
  // Same-cycle answer, as the bank samples it with the strobe
  assign ext_rdata = mem[ptr[3:0]];
  always @(posedge clk) if (ext_wr) mem[ext_addr[3:0]] <= ext_wdata;
endmodule

// ==== pcx_regbank_tb.sv ====
/* Self-checking bench for pcx_regbank.
   Assumes 125 MHz clk; receive error, MLT-3 and SNR lines toggle from an unrelated 80 ns clock. */
`timescale 1ns/1ps
module pcx_regbank_tb;
  logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, lk = 0, ce = 1;
  logic [3:0]  ev = 0;
  logic [4:0]  reg_addr = 0;
  logic [15:0] reg_wdata = 0, ep = 0, ext_rdata, reg_rdata, ext_addr, ext_wdata;
  logic        ext_wr, ext_rd, pol_normal, pair_swap, port_mirror, link_drop;
  int          num_errors = 0, num_checks = 0;
  logic [36:0] rows [5] = '{{5'h0b, 16'hffff, 16'h007f}, {5'h0d, 16'hffff, 16'hc01f},
    {5'h03, 16'hffff, 16'h0000}, {5'h0d, 16'h001f, 16'h001f}, {5'h0e, 16'h1234, 16'h1234}};
  always #4 clk = ~clk;
  initial begin
    #3;
    forever #40 lk = ~lk;
  end
  // Short window keeps the run brief
  pcx_regbank #(.WIN_CYC(400)) i_pcx_regbank (.clk(clk), .rst_n(rst_n), .clk_en(ce), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .ext_rdata(ext_rdata),
    .rx_err_pin(lk & ev[3]), .mlt3_viol_pin(lk & ev[2]), .low_snr_pin(lk & ev[1]), .energy_loss_pin(ev[0]),
    .reg_rdata(reg_rdata), .ext_wr(ext_wr), .ext_rd(ext_rd), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .pol_normal(pol_normal), .pair_swap(pair_swap), .port_mirror(port_mirror), .link_drop(link_drop));
  pcx_ext_model i_pcx_ext_model (.clk(clk), .ext_wr(ext_wr), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ptr(ep), .ext_rdata(ext_rdata));
  task complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk); reg_wr = 1; reg_addr = a; reg_wdata = d;
    @(negedge clk); reg_wr = 0;
  endtask
  task rd(input logic [4:0] a, input logic [15:0] e);
    @(negedge clk); reg_rd = 1; reg_addr = a;
    @(negedge clk); reg_rd = 0;
    @(negedge clk); chk("rdata", reg_rdata, e);
  endtask
  // Bounded wait for a drop; exp 0 waits out the whole bound
  task drop(input logic [3:0] e, input logic exp);
    repeat (410) @(negedge clk);
    ev = e;
    for (int i = 0; i < 900 && link_drop !== 1'b1; i++) @(negedge clk);
    chk("link_drop", {15'h0, link_drop}, {15'h0, exp});
    if (link_drop !== exp) complete_run;
    ev = 0;
    for (int i = 0; i < 900 && link_drop !== 1'b0; i++) @(negedge clk);
    chk("link_drop_clear", {15'h0, link_drop}, 16'h0000);
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1;
    rd(5'h0b, 0);
    rd(5'h0d, 0);
    foreach (rows[i]) begin
      wr(rows[i][36:32], rows[i][31:16]);
      rd(rows[i][36:32], rows[i][15:0]);
    end
    chk("mirror", {13'h0, pol_normal, pair_swap, port_mirror}, 16'h0007);
    wr(5'h0b, 16'h0020); repeat (2) @(negedge clk);
    chk("pairs", {13'h0, pol_normal, pair_swap, port_mirror}, 16'h0002);
    wr(5'h0e, 16'hfffe); wr(5'h0d, 16'h801f); wr(5'h0e, 16'haaaa); ep = 16'hffff;
    rd(5'h0e, 16'hffff);
    ep = 0; wr(5'h0d, 16'hc01f);
    rd(5'h0e, 16'h0000);
    wr(5'h0e, 16'h5555); ep = 1; wr(5'h0d, 16'h401f);
    rd(5'h0e, 16'h1111);
    wr(5'h0d, 16'h001f);
    rd(5'h0e, 16'h0001);
    wr(5'h0e, 16'hfffe); ep = 16'hfffe; wr(5'h0d, 16'h401f);
    rd(5'h0e, 16'haaaa);
    wr(5'h0d, 16'h401e); wr(5'h0e, 16'h9999);
    rd(5'h0e, 16'h0000);
    wr(5'h0d, 16'h001f);
    rd(5'h0e, 16'hfffe);
    wr(5'h0b, 16'h0000); drop(4'he, 0);
    wr(5'h0b, 16'h0001); drop(4'h1, 1);
    wr(5'h0b, 16'h0004); drop(4'h4, 1);
    wr(5'h0b, 16'h0008); drop(4'h8, 1);
    wr(5'h0b, 16'h000a); drop(4'h2, 1);
    ce = 0; wr(5'h0b, 16'h007f); ce = 1;
    rd(5'h0b, 16'h000a);
    wr(5'h0b, 16'h0060); repeat (2) @(negedge clk);
    chk("mirror_on", {13'h0, pol_normal, pair_swap, port_mirror}, 16'h0007);
    rst_n = 0; repeat (2) @(negedge clk); rst_n = 1;
    chk("reset_outs", {12'h0, pol_normal, pair_swap, port_mirror, link_drop}, 16'h0000);
    rd(5'h0b, 16'h0000);
    rd(5'h0d, 16'h0000);
    rd(5'h0e, 16'h0000);
    wr(5'h0d, 16'h001f);
    rd(5'h0e, 16'h0000);
    complete_run;
  end
endmodule
